// *** shared/rst_seq_pkg.sv ***
// Constants for the reset and STOP release controller.
// Assumes a single 10 MHz core clock; all sources arrive as levels or
// one-cycle pulses, pins and detectors asynchronous to that clock.
//
// Summary of operation
// - reset in STOP ends standby, then resets
// - unmasked default-priority request wakes; enable picks service
// - high-priority wake serviced only with both enables
// - four reset sources: pin, watchdog, power clear, LVD
// - every reset restarts from vector 0000H/0001H
// - pin low holds reset, high releases
// - pins high impedance in reset and stabilization
// - watchdog reset releases itself
// - power clear/LVD reset releases when supply recovers
// - oscillators stopped, external clock ignored in reset
// - reset from STOP keeps held state, pins float
// - cause register records watchdog and LVD resets
// - LVD reset spares LVD control registers
// - watchdog reset also reinitializes watchdog
// - reset stops CPU clock and peripherals
// - only program counter undefined during reset
package rst_seq_pkg;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int PIN_LOW_MIN_US = 10;
   localparam int PIN_LOW_CYC =
      (PIN_LOW_MIN_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int OSC_STAB_DEF = 256;
   localparam int WDT_RST_CYC = 4;
   localparam int CNT_W = 16;

   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam logic [3:0] ADDR_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_INT_STAT = 4'h4;
   localparam logic [3:0] ADDR_INT_MASK = 4'h8;
   localparam int CAUSE_WDT_BIT = 0;
   localparam int CAUSE_LVD_BIT = 1;
   localparam int EV_RELEASE_BIT = 0;
   localparam int EV_WAKE_BIT = 1;
   localparam int NUM_EV = 2;
   localparam logic [1:0] CAUSE_RST = 2'h0;
   localparam logic [1:0] INT_RST = 2'h0;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_STOP,
      ST_HOLD,
      ST_STAB,
      ST_PROC
   } seq_state_e;

endpackage : rst_seq_pkg

// *** rtl/rst_seq.sv ***
// Reset combiner, reset sequencer and STOP release decision.
// Assumes the CPU pulses stop_enter when it executes STOP and reads the
// vector at vector_addr when vector_load pulses.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module rst_seq
   import rst_seq_pkg::*;
#(
   parameter int OSC_STAB_CYC = OSC_STAB_DEF
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   input wire logic wdt_overflow,
   input wire logic pwr_clear_low,
   input wire logic lvd_low,
   input wire logic stop_enter,
   input wire logic intr_req,
   input wire logic interrupt_mask_flag,
   input wire logic interrupt_priority_flag,
   input wire logic global_interrupt_enable,
   input wire logic in_service_priority_flag,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic sys_reset,
   output logic cpu_clk_en,
   output logic osc_stop,
   output logic ext_clk_ignore,
   output logic pins_hiz,
   output logic periph_reset,
   output logic lvd_regs_reset,
   output logic wdt_reset,
   output logic pc_undefined,
   output logic stop_hold,
   output logic stop_active,
   output logic wake_next,
   output logic wake_service,
   output logic vector_load,
   output logic [15:0] vector_addr,
   output logic irq
);

   localparam logic [CNT_W-1:0] PIN_LOW_LIM = CNT_W'(PIN_LOW_CYC);
   localparam logic [CNT_W-1:0] STAB_LOAD = CNT_W'(OSC_STAB_CYC);
   localparam logic [3:0] WDT_LOAD = 4'(WDT_RST_CYC);

   // -------------------------------------------------------------------
   // synchronisers for pin and detector levels
   // -------------------------------------------------------------------
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= 3'h1;
         sync2_ff <= 3'h1;
      end else begin
         sync1_ff <= {lvd_low, pwr_clear_low, reset_pin_n};
         sync2_ff <= sync1_ff;
      end
   end

   logic pin_s_n;
   logic pwr_clear_s;
   logic lvd_s;
   assign pin_s_n = sync2_ff[0];
   assign pwr_clear_s = sync2_ff[1];
   assign lvd_s = sync2_ff[2];

   // -------------------------------------------------------------------
   // pin low filter
   // -------------------------------------------------------------------
   // glitches shorter than the minimum width are not taken as a reset
   logic [CNT_W-1:0] pin_low_cnt_ff;
   logic pin_rst;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_low_cnt_ff <= '0;
      end else if (pin_s_n) begin
         pin_low_cnt_ff <= '0;
      end else if (pin_low_cnt_ff != PIN_LOW_LIM) begin
         pin_low_cnt_ff <= pin_low_cnt_ff + 1'b1;
      end
   end

   assign pin_rst = !pin_s_n && (pin_low_cnt_ff == PIN_LOW_LIM);

   // -------------------------------------------------------------------
   // watchdog reset pulse stretcher
   // -------------------------------------------------------------------
   logic [3:0] wdt_cnt_ff;
   logic wdt_hold;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wdt_cnt_ff <= '0;
      end else if (wdt_overflow) begin
         wdt_cnt_ff <= WDT_LOAD;
      end else if (wdt_cnt_ff != 4'h0) begin
         wdt_cnt_ff <= wdt_cnt_ff - 1'b1;
      end
   end

   assign wdt_hold = (wdt_cnt_ff != 4'h0);

   logic any_src;
   assign any_src = pin_rst || wdt_hold || pwr_clear_s || lvd_s;

   // -------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------
   seq_state_e state_ff;
   seq_state_e nxt_state;
   logic [CNT_W-1:0] stab_cnt_ff;
   logic from_stop_ff;
   logic wake;
   logic wake_svc;

   assign wake = intr_req && !interrupt_mask_flag;
   // high priority needs both enables; default priority only global enable
   assign wake_svc = global_interrupt_enable &&
      (!interrupt_priority_flag || in_service_priority_flag);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RUN: begin
            if (any_src) begin
               nxt_state = ST_HOLD;
            end else if (stop_enter) begin
               nxt_state = ST_STOP;
            end
         end
         ST_STOP: begin
            if (any_src) begin
               nxt_state = ST_HOLD;
            end else if (wake) begin
               nxt_state = ST_RUN;
            end
         end
         ST_HOLD: begin
            if (!any_src) begin
               nxt_state = ST_STAB;
            end
         end
         ST_STAB: begin
            if (any_src) begin
               nxt_state = ST_HOLD;
            end else if (stab_cnt_ff <= 16'h0001) begin
               nxt_state = ST_PROC;
            end
         end
         ST_PROC: begin
            nxt_state = any_src ? ST_HOLD : ST_RUN;
         end
         default: begin
            nxt_state = ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_HOLD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stab_cnt_ff <= '0;
      end else if (nxt_state == ST_STAB && state_ff != ST_STAB) begin
         stab_cnt_ff <= STAB_LOAD;
      end else if (state_ff == ST_STAB && stab_cnt_ff != '0) begin
         stab_cnt_ff <= stab_cnt_ff - 1'b1;
      end
   end

   // remembers that the reset hit during STOP so its state is kept
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         from_stop_ff <= 1'b0;
      end else if (state_ff == ST_STOP && any_src) begin
         from_stop_ff <= 1'b1;
      end else if (state_ff != ST_HOLD) begin
         from_stop_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // registered event pulses to the CPU
   // -------------------------------------------------------------------
   logic wake_next_ff;
   logic wake_svc_ff;
   logic vec_ff;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wake_next_ff <= 1'b0;
         wake_svc_ff <= 1'b0;
         vec_ff <= 1'b0;
      end else begin
         wake_next_ff <= state_ff == ST_STOP && !any_src && wake &&
            !wake_svc;
         wake_svc_ff <= state_ff == ST_STOP && !any_src && wake &&
            wake_svc;
         vec_ff <= state_ff == ST_STAB && nxt_state == ST_PROC;
      end
   end

   logic in_rst;
   assign in_rst = (state_ff == ST_HOLD);

   assign sys_reset = in_rst;
   assign cpu_clk_en = (state_ff == ST_RUN);
   assign osc_stop = in_rst;
   assign ext_clk_ignore = in_rst;
   assign pins_hiz = in_rst || state_ff == ST_STAB;
   assign periph_reset = in_rst && !from_stop_ff;
   assign stop_hold = in_rst && from_stop_ff;
   // lvd control survives its own reset
   assign lvd_regs_reset = pin_rst || pwr_clear_s || wdt_hold;
   assign wdt_reset = wdt_hold;
   assign pc_undefined = in_rst || state_ff == ST_STAB;
   assign stop_active = (state_ff == ST_STOP);
   assign wake_next = wake_next_ff;
   assign wake_service = wake_svc_ff;
   assign vector_load = vec_ff;
   assign vector_addr = RESET_VECTOR_ADDR;

   // -------------------------------------------------------------------
   // cause flags
   // -------------------------------------------------------------------
   logic [1:0] cause_ff;
   logic cause_clr;
   assign cause_clr = pin_rst || pwr_clear_s;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cause_ff <= CAUSE_RST;
      end else begin
         // a fresh cause wins over a simultaneous clearing source
         if (wdt_overflow) begin
            cause_ff[CAUSE_WDT_BIT] <= 1'b1;
         end else if (cause_clr) begin
            cause_ff[CAUSE_WDT_BIT] <= 1'b0;
         end
         if (lvd_s) begin
            cause_ff[CAUSE_LVD_BIT] <= 1'b1;
         end else if (cause_clr) begin
            cause_ff[CAUSE_LVD_BIT] <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // interrupt status and mask
   // -------------------------------------------------------------------
   logic [NUM_EV-1:0] int_stat_ff;
   logic [NUM_EV-1:0] int_mask_ff;
   logic [NUM_EV-1:0] ev;
   assign ev = {wake_next_ff || wake_svc_ff, vec_ff};

   generate
      for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               int_stat_ff[i] <= 1'b0;
            end else if (ev[i]) begin
               int_stat_ff[i] <= 1'b1;
            end else if (reg_wr && reg_addr == ADDR_INT_STAT &&
                         reg_wdata[i]) begin
               int_stat_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         int_mask_ff <= INT_RST;
      end else if (reg_wr && reg_addr == ADDR_INT_MASK) begin
         int_mask_ff <= reg_wdata[NUM_EV-1:0];
      end
   end

   assign irq = |(int_stat_ff & int_mask_ff);

   // -------------------------------------------------------------------
   // read port
   // -------------------------------------------------------------------
   logic [7:0] rdata_ff;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_CAUSE: rdata_ff <= {6'h00, cause_ff};
            ADDR_INT_STAT: rdata_ff <= {6'h00, int_stat_ff};
            ADDR_INT_MASK: rdata_ff <= {6'h00, int_mask_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   localparam int WDT_MAX = WDT_RST_CYC + 1;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence stab_done_s;
      state_ff == ST_STAB && stab_cnt_ff == 16'h0001 && !any_src;
   endsequence

   sequence restart_s;
      state_ff == ST_PROC && vector_load ##1 state_ff == ST_RUN;
   endsequence

   pin_filter_a: assert property (
      !pin_s_n && pin_low_cnt_ff != PIN_LOW_LIM
      |=> pin_low_cnt_ff == $past(pin_low_cnt_ff) + 16'h0001)
      else $error("pin low width count skipped a cycle");

   reset_entry_a: assert property (
      any_src && state_ff != ST_HOLD |=> state_ff == ST_HOLD)
      else $error("reset source did not enter reset");

   stop_masked_a: assert property (
      state_ff == ST_STOP && intr_req && interrupt_mask_flag && !any_src
      |=> state_ff == ST_STOP)
      else $error("masked request left STOP");

   stop_wake_a: assert property (
      state_ff == ST_STOP && wake && !any_src
      |=> state_ff == ST_RUN && (wake_next ^ wake_service) &&
          wake_service == $past(wake_svc))
      else $error("wrong STOP release decision");

   restart_seq_a: assert property (
      stab_done_s |=> restart_s)
      else $error("release did not restart from vector");

   pins_float_a: assert property (
      state_ff == ST_HOLD || state_ff == ST_STAB
      |-> pins_hiz && !cpu_clk_en && pc_undefined)
      else $error("pins driven during reset");

   wdt_release_a: assert property (
      wdt_overflow |=> wdt_reset ##[1:WDT_MAX] !wdt_reset)
      else $error("watchdog reset did not release");

   wdt_flag_a: assert property (
      wdt_overflow |=> cause_ff[CAUSE_WDT_BIT])
      else $error("watchdog cause not recorded");

   lvd_keep_a: assert property (
      lvd_s && !pin_rst && !pwr_clear_s && !wdt_hold |-> !lvd_regs_reset)
      else $error("lvd reset cleared its own registers");

   cause_clear_a: assert property (
      pin_rst && !wdt_overflow && !lvd_s |=> cause_ff == 2'h0)
      else $error("cause flags not cleared");

   stop_keep_a: assert property (
      state_ff == ST_STOP && any_src |=> stop_hold && !periph_reset)
      else $error("STOP state not kept in reset");

endmodule : rst_seq

// *** dv/src_model.sv ***
// Far-side model: external reset pin driver and watchdog overflow source.
// Assumes the bench gives one-cycle requests on core_clk.
`timescale 1ns/100ps
module src_model (
   input wire logic core_clk,
   input wire logic pin_go,
   input wire logic [7:0] pin_len,
   input wire logic wdt_go,
   output logic reset_pin_n,
   output logic wdt_overflow
);
   logic [7:0] low_ff = 8'h00;
   logic wdt_ff = 1'b0;

   // pin has a pull-up, so it returns high once released
   always_ff @(posedge core_clk) begin
      if (pin_go) begin
         low_ff <= pin_len;
      end else if (low_ff != 8'h00) begin
         low_ff <= low_ff - 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      wdt_ff <= wdt_go;
   end

   assign reset_pin_n = (low_ff == 8'h00);
   assign wdt_overflow = wdt_ff;
endmodule : src_model

// *** dv/reset_and_stop_release_control_tb_top.sv ***
// Self-checking bench for the reset and STOP release controller.
// Assumes a short oscillation wait (4 cycles) is legal for the design.
`timescale 1ns/100ps
module reset_and_stop_release_control_tb_top;
   import rst_seq_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, pwr_clear_low = 1'b0, lvd_low = 1'b0;
   logic stop_enter = 1'b0, intr_req = 1'b0, interrupt_mask_flag = 1'b0;
   logic interrupt_priority_flag = 1'b0, global_interrupt_enable = 1'b0;
   logic in_service_priority_flag = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, pin_len = 8'h00, reg_rdata;
   logic pin_go = 1'b0, wdt_go = 1'b0, reset_pin_n, wdt_overflow;
   logic sys_reset, cpu_clk_en, osc_stop, ext_clk_ignore, pins_hiz;
   logic periph_reset, lvd_regs_reset, wdt_reset, pc_undefined, stop_hold;
   logic stop_active, wake_next, wake_service, vector_load, irq;
   logic [15:0] vector_addr;
   int num_errors = 0;
   int total_checks = 0;

   always #50 core_clk = ~core_clk;

   src_model src_model_i (.core_clk, .pin_go, .pin_len, .wdt_go,
      .reset_pin_n, .wdt_overflow);
   rst_seq #(.OSC_STAB_CYC(4)) rst_seq_i (.core_clk, .rst, .reset_pin_n,
      .wdt_overflow, .pwr_clear_low, .lvd_low, .stop_enter, .intr_req,
      .interrupt_mask_flag, .interrupt_priority_flag,
      .global_interrupt_enable, .in_service_priority_flag, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_reset, .cpu_clk_en,
      .osc_stop, .ext_clk_ignore, .pins_hiz, .periph_reset, .lvd_regs_reset,
      .wdt_reset, .pc_undefined, .stop_hold, .stop_active, .wake_next,
      .wake_service, .vector_load, .vector_addr, .irq);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen,
         input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task automatic hang(input string nm);
      num_errors++;
      $display("unexpected %s: expected event seen timeout", nm);
      test_done();
   endtask : hang

   task automatic rd(input logic [3:0] a, input logic [7:0] exp,
         input string nm);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, reg_rdata, exp);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic wait_rst;
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge core_clk);
         #1;
         if (sys_reset === 1'b1) break;
      end
      if (n == 200) hang("sys_reset");
   endtask : wait_rst

   // vector fetch must come before the cpu clock returns
   task automatic wait_run;
      int n;
      logic seen_vec;
      seen_vec = 1'b0;
      for (n = 0; n < 300; n++) begin
         @(posedge core_clk);
         #1;
         if (vector_load === 1'b1) begin
            seen_vec = 1'b1;
            chk("vector_addr", vector_addr, 16'h0000);
         end
         if (cpu_clk_en === 1'b1) break;
      end
      if (n == 300) hang("cpu_clk_en");
      chk("vector_load", seen_vec, 1'b1);
   endtask : wait_run

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_boot;
      @(posedge core_clk);
      #1 chk("pins_hiz", pins_hiz, 1'b1);
      chk("pc_undef", pc_undefined, 1'b1);
      wait_run();
      rd(ADDR_CAUSE, 8'h00, "cause");
      $display("test boot finished");
   endtask : t_boot

   task automatic t_irq;
      rd(ADDR_INT_STAT, 8'h01, "int_stat");
      chk("irq", irq, 1'b0);
      wr(ADDR_INT_MASK, 8'h01);
      chk("irq", irq, 1'b1);
      wr(ADDR_INT_STAT, 8'h01);
      chk("irq", irq, 1'b0);
      rd(ADDR_INT_STAT, 8'h00, "int_stat");
      rd(4'hC, 8'h00, "unmapped");
      wr(ADDR_CAUSE, 8'hFF);
      rd(ADDR_CAUSE, 8'h00, "cause");
      wr(ADDR_INT_MASK, 8'h00);
      $display("test irq finished");
   endtask : t_irq

   task automatic t_lvd;
      @(posedge core_clk);
      lvd_low <= 1'b1;
      wait_rst();
      repeat (4) @(posedge core_clk);
      #1 chk("osc_stop", osc_stop, 1'b1);
      chk("ext_clk_ign", ext_clk_ignore, 1'b1);
      chk("cpu_clk_en", cpu_clk_en, 1'b0);
      chk("periph_rst", periph_reset, 1'b1);
      chk("lvd_regs_rst", lvd_regs_reset, 1'b0);
      chk("sys_reset", sys_reset, 1'b1);
      @(posedge core_clk);
      lvd_low <= 1'b0;
      wait_run();
      rd(ADDR_CAUSE, 8'h02, "cause");
      $display("test lvd finished");
   endtask : t_lvd

   task automatic t_pwr_clear;
      @(posedge core_clk);
      pwr_clear_low <= 1'b1;
      wait_rst();
      chk("lvd_regs_rst", lvd_regs_reset, 1'b1);
      @(posedge core_clk);
      pwr_clear_low <= 1'b0;
      wait_run();
      rd(ADDR_CAUSE, 8'h00, "cause");
      $display("test power_clear finished");
   endtask : t_pwr_clear

   task automatic t_wdt;
      @(posedge core_clk);
      wdt_go <= 1'b1;
      @(posedge core_clk);
      wdt_go <= 1'b0;
      wait_rst();
      chk("wdt_reset", wdt_reset, 1'b1);
      chk("lvd_regs_rst", lvd_regs_reset, 1'b1);
      wait_run();
      rd(ADDR_CAUSE, 8'h01, "cause");
      $display("test wdt finished");
   endtask : t_wdt

   // a pin pulse below the minimum must not reset
   task automatic t_pin_short;
      logic hit;
      hit = 1'b0;
      @(posedge core_clk);
      pin_go <= 1'b1;
      pin_len <= 8'd50;
      @(posedge core_clk);
      pin_go <= 1'b0;
      repeat (80) begin
         @(posedge core_clk);
         #1 hit |= sys_reset;
      end
      chk("short_pin", hit, 1'b0);
      $display("test pin_short finished");
   endtask : t_pin_short

   task automatic stop_case(input logic [5:0] row);
      logic svc, nxt;
      svc = 1'b0;
      nxt = 1'b0;
      @(posedge core_clk);
      {interrupt_mask_flag, interrupt_priority_flag, global_interrupt_enable,
         in_service_priority_flag} <= row[5:2];
      stop_enter <= 1'b1;
      @(posedge core_clk);
      stop_enter <= 1'b0;
      intr_req <= 1'b1;
      #1 chk("stop_active", stop_active, 1'b1);
      repeat (3) begin
         @(posedge core_clk);
         #1 svc |= wake_service;
         nxt |= wake_next;
      end
      chk("wake", {svc, nxt}, row[1:0]);
      chk("held", stop_active, row[1:0] == 2'b00);
      @(posedge core_clk);
      interrupt_mask_flag <= 1'b0;
      repeat (3) @(posedge core_clk);
      intr_req <= 1'b0;
      #1 chk("stop_left", stop_active, 1'b0);
   endtask : stop_case

   // mask, priority, enable, in-service, then service and next
   task automatic t_stop;
      logic [5:0] tbl [6] = '{6'h01, 6'h0A, 6'h15, 6'h19, 6'h1E, 6'h2C};
      foreach (tbl[i]) stop_case(tbl[i]);
      $display("test stop finished");
   endtask : t_stop

   task automatic t_stop_pin;
      @(posedge core_clk);
      interrupt_mask_flag <= 1'b1;
      stop_enter <= 1'b1;
      @(posedge core_clk);
      stop_enter <= 1'b0;
      pin_go <= 1'b1;
      pin_len <= 8'd110;
      @(posedge core_clk);
      pin_go <= 1'b0;
      wait_rst();
      chk("stop_hold", stop_hold, 1'b1);
      chk("periph_rst", periph_reset, 1'b0);
      chk("pins_hiz", pins_hiz, 1'b1);
      wait_run();
      chk("stop_active", stop_active, 1'b0);
      rd(ADDR_CAUSE, 8'h00, "cause");
      interrupt_mask_flag <= 1'b0;
      $display("test stop_pin finished");
   endtask : t_stop_pin

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_boot();
      t_irq();
      t_lvd();
      t_pwr_clear();
      t_wdt();
      t_pin_short();
      t_stop();
      t_stop_pin();
      test_done();
   end
endmodule : reset_and_stop_release_control_tb_top
